// *** src/sync_line_defines.svh ***
// offsets, field positions, reset values and timing counts of the sync line registers
`ifndef SYNC_LINE_DEFINES_SVH
`define SYNC_LINE_DEFINES_SVH
`define IND_REG_PARAM      3'h0
`define IND_REG_RXERR      3'h1
`define IND_SEL_W          3
`define F_ERRCTL_LO        0
`define F_PROTO_LO         3
`define F_STRIP_BIT        6
`define F_RXBPC_LO         8
`define F_SPARE_LO         11
`define F_TXBPC_LO         13
`define F_RESID_LO         8
`define B_RX_OVERRUN       1
`define B_RX_DMA_ERR       2
`define PARAM_RESET        16'h0000
`define RXERR_RESET        8'h00
`define RESID_RESET        3'h0
`define DMA_TIMEOUT_NS     32000
`define CLOCK_PERIOD_NS    10
`define DMA_TIMEOUT_CYCLES ((`DMA_TIMEOUT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// *** src/sync_line_pkg.sv ***
// types shared by the sync line register bank
package sync_line_pkg;
  typedef enum logic [2:0] {
    PROTO_DDCMP, PROTO_SDLC, PROTO_HDLC, PROTO_SPARE, PROTO_GENERIC_BYTE_SYNC_MODE
  } proto_t;
  typedef enum logic [2:0] {
    EC_CCITT_ONES, EC_CCITT_ZEROS, EC_LRC_VRC_ODD, EC_CRC16,
    EC_LRC_ODD, EC_LRC_EVEN, EC_LRC_VRC_EVEN, EC_NONE
  } errctl_t;
endpackage

// *** src/dma_sync_timeout.sv ***
// bus master handshake watchdog: flags a missing slave_sync_response
`timescale 1ns/1ns
`include "sync_line_defines.svh"
module dma_sync_timeout #(
  parameter int TIMEOUT_CYCLES = `DMA_TIMEOUT_CYCLES
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic master_sync_request,
  input  wire logic slave_sync_response,
  output logic      timeout
);
  typedef enum logic [1:0] {T_IDLE, T_WAIT, T_DONE} tstate_t;
  tstate_t     state_q;
  logic [12:0] count_q;
  logic        slave_sync_response_meta_q;
  logic        slave_sync_response_q;

  // response comes off the bus pins, so two flops before use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slave_sync_response_meta_q <= 1'b0;
      slave_sync_response_q      <= 1'b0;
    end else begin
      slave_sync_response_meta_q <= slave_sync_response;
      slave_sync_response_q      <= slave_sync_response_meta_q;
    end
  end

  // count while the request stands unanswered; one report per request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= T_IDLE;
      count_q <= 13'h0000;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      case (state_q)
        T_IDLE: begin
          count_q <= 13'h0000;
          if (master_sync_request) begin
            state_q <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (!master_sync_request || slave_sync_response_q) begin
            state_q <= T_IDLE;
          end else if (count_q == 13'(TIMEOUT_CYCLES - 1)) begin
            timeout <= 1'b1;
            state_q <= T_DONE;
          end else begin
            count_q <= count_q + 13'h0001;
          end
        end
        default: begin
          // hold until the master drops its request
          if (!master_sync_request) begin
            state_q <= T_IDLE;
          end
        end
      endcase
    end
  end

  a_timeout_wait: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(timeout) |-> state_q == T_DONE && count_q == 13'(TIMEOUT_CYCLES - 1))
    else $error("timeout raised before the full wait");
endmodule

// *** src/sync_line_regs.sv ***
// protocol parameter and receive error indirect registers of the sync line
//
// Function
// - the protocol field decodes 000 ddcmp, 001 sdlc, 010 hdlc, 111 generic byte, others spare.
// - receive width code 000 means eight bits and codes 001 to 111 mean one to seven bits.
// - transmit width code 000 means eight bits and codes 001 to 111 mean one to seven bits.
// - the second indirect register holds the error byte low and the residual count above it.
// - for bit protocols the residual count tells how many bits of the last stored char count.
// - bit 1 is set when received characters arrive faster than they can be stored.
// - the overrun flag clears on master reset, bus init or a read of the error low byte.
// - bit 2 is set when slave sync does not answer master sync within 32 us.
// - setting the dma error flag clears the receiver enable bit.
// - the dma error flag clears on master reset, bus init or a read of the error low byte.
// - the error control field decodes the eight block check kinds, 111 meaning none.
// - only generic byte mode obeys the strip sync bit; other protocols always strip sync.
// - the error byte clears on master reset and init; the parameter word survives both.
`timescale 1ns/1ns
`include "sync_line_defines.svh"
module sync_line_regs
  import sync_line_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `DMA_TIMEOUT_CYCLES
) (
  input  wire logic                      CLOCK,
  input  wire logic                      ARST_N,
  input  wire logic                      MASTER_RESET,
  input  wire logic                      BUS_INIT,
  input  wire logic [`IND_SEL_W-1:0]     IND_SEL,
  input  wire logic [1:0]                BYTE_EN,
  input  wire logic                      WR_EN,
  input  wire logic [15:0]               WR_DATA,
  input  wire logic                      RD_EN,
  output logic [15:0]                    RD_DATA,
  output logic                           RD_VALID,
  input  wire logic                      RX_OVERRUN_EVENT,
  input  wire logic                      MASTER_SYNC_REQUEST,
  input  wire logic                      SLAVE_SYNC_RESPONSE,
  input  wire logic                      LAST_CHAR_STORED,
  input  wire logic [2:0]                LAST_CHAR_BITS,
  output logic                           RX_ENABLE_CLEAR,
  output sync_line_pkg::proto_t          PROTOCOL,
  output sync_line_pkg::errctl_t         ERROR_CONTROL,
  output logic                           STRIP_SYNC,
  output logic [3:0]                     RX_BITS_PER_CHAR,
  output logic [3:0]                     TX_BITS_PER_CHAR
);
  import sync_line_pkg::*;

  logic [15:0] param_q;
  logic [7:1]  rxerr_q;
  logic [2:0]  resid_q;
  logic        dma_timeout;
  logic        sel_param;
  logic        sel_rxerr;
  logic        rd_err_lo;

  assign sel_param = IND_SEL == `IND_REG_PARAM;
  assign sel_rxerr = IND_SEL == `IND_REG_RXERR;
  assign rd_err_lo = RD_EN && sel_rxerr && BYTE_EN[0];

  dma_sync_timeout #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_timeout (
    .clock               (CLOCK),
    .arst_n              (ARST_N),
    .master_sync_request (MASTER_SYNC_REQUEST),
    .slave_sync_response (SLAVE_SYNC_RESPONSE),
    .timeout             (dma_timeout)
  );

  // parameter word: byte writes; master reset and init leave it alone
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      param_q <= `PARAM_RESET;
    end else if (WR_EN && sel_param) begin
      if (BYTE_EN[0]) begin
        param_q[7:0] <= {1'b0, WR_DATA[6:0]}; // bit 7 is unused and kept zero
      end
      if (BYTE_EN[1]) begin
        param_q[15:8] <= WR_DATA[15:8];
      end
    end
  end

  // error flags: an event in the clearing read's cycle wins, so none is lost
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rxerr_q <= 7'h00;
    end else begin
      if (MASTER_RESET || BUS_INIT || rd_err_lo) begin
        rxerr_q <= 7'h00;
      end
      if (RX_OVERRUN_EVENT) begin
        rxerr_q[`B_RX_OVERRUN] <= 1'b1;
      end
      if (dma_timeout) begin
        rxerr_q[`B_RX_DMA_ERR] <= 1'b1;
      end
    end
  end

  // residual count of the last stored character; software may also write it
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      resid_q <= `RESID_RESET;
    end else if (LAST_CHAR_STORED) begin
      resid_q <= LAST_CHAR_BITS;
    end else if (WR_EN && sel_rxerr && BYTE_EN[1]) begin
      resid_q <= WR_DATA[`F_RESID_LO +: 3];
    end
  end

  // the receive csr owns the enable bit; a one-cycle pulse tells it to drop
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_ENABLE_CLEAR <= 1'b0;
    end else begin
      RX_ENABLE_CLEAR <= dma_timeout;
    end
  end

  // read port: data one cycle after the strobe, unselected lanes read zero
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA  <= 16'h0000;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_EN;
      if (RD_EN) begin
        RD_DATA <= 16'h0000;
        if (sel_param) begin
          RD_DATA <= param_q & {{8{BYTE_EN[1]}}, {8{BYTE_EN[0]}}};
        end else if (sel_rxerr) begin
          RD_DATA[7:0] <= BYTE_EN[0] ? {rxerr_q, 1'b0} : 8'h00;
          RD_DATA[`F_RESID_LO +: 3] <= BYTE_EN[1] ? resid_q : 3'h0;
        end
      end
    end
  end

  // decoded controls registered from the word, one cycle behind a write
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PROTOCOL         <= PROTO_DDCMP;
      ERROR_CONTROL    <= EC_CCITT_ONES;
      STRIP_SYNC       <= 1'b1;
      RX_BITS_PER_CHAR <= 4'h8;
      TX_BITS_PER_CHAR <= 4'h8;
    end else begin
      case (param_q[`F_PROTO_LO +: 3])
        3'h0:    PROTOCOL <= PROTO_DDCMP;
        3'h1:    PROTOCOL <= PROTO_SDLC;
        3'h2:    PROTOCOL <= PROTO_HDLC;
        3'h7:    PROTOCOL <= PROTO_GENERIC_BYTE_SYNC_MODE;
        default: PROTOCOL <= PROTO_SPARE;
      endcase
      ERROR_CONTROL <= errctl_t'(param_q[`F_ERRCTL_LO +: 3]);
      // other protocols strip sync regardless of the bit
      STRIP_SYNC <= (param_q[`F_PROTO_LO +: 3] == 3'h7) ? param_q[`F_STRIP_BIT] : 1'b1;
      RX_BITS_PER_CHAR <= {param_q[`F_RXBPC_LO +: 3] == 3'h0, param_q[`F_RXBPC_LO +: 3]};
      TX_BITS_PER_CHAR <= {param_q[`F_TXBPC_LO +: 3] == 3'h0, param_q[`F_TXBPC_LO +: 3]};
    end
  end

  a_overrun_set: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    RX_OVERRUN_EVENT |=> rxerr_q[`B_RX_OVERRUN])
    else $error("overrun event did not set its flag");
  a_dma_err_set: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    dma_timeout |=> rxerr_q[`B_RX_DMA_ERR] && RX_ENABLE_CLEAR)
    else $error("dma timeout did not set flag and clear enable");
  a_rxen_cause: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    RX_ENABLE_CLEAR |-> $past(dma_timeout))
    else $error("receiver enable cleared without a dma error");
  a_read_clears: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    rd_err_lo && !RX_OVERRUN_EVENT && !dma_timeout |=> rxerr_q == 7'h00)
    else $error("reading the error byte did not clear it");
  a_reset_clears: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (MASTER_RESET || BUS_INIT) && !RX_OVERRUN_EVENT && !dma_timeout && !WR_EN
      |=> rxerr_q == 7'h00 && param_q == $past(param_q))
    else $error("master reset or init handled the registers wrongly");
  a_bit0_zero: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    RD_EN && sel_rxerr |=> !RD_DATA[0])
    else $error("unused error bit read as one");
  a_rx_width: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    param_q[`F_RXBPC_LO +: 3] == 3'h0 |=> RX_BITS_PER_CHAR == 4'h8)
    else $error("receive width code zero is not eight bits");
  a_tx_width: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    param_q[`F_TXBPC_LO +: 3] != 3'h0 |=> TX_BITS_PER_CHAR == {1'b0, $past(param_q[15:13])})
    else $error("transmit width decode wrong");
  a_proto_gen: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    param_q[`F_PROTO_LO +: 3] == 3'h7 |=> PROTOCOL == PROTO_GENERIC_BYTE_SYNC_MODE)
    else $error("generic byte code not decoded");
  a_strip_fixed: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    PROTOCOL != PROTO_GENERIC_BYTE_SYNC_MODE |-> STRIP_SYNC)
    else $error("sync not stripped outside generic byte mode");
endmodule

// *** testbench/dma_slave_model.sv ***
// bus slave model that answers the dma master sync handshake
`timescale 1ns/1ns
module dma_slave_model (
  input  wire logic       clock,
  input  wire logic       master_sync_request,
  input  wire logic [7:0] answer_delay,
  output logic            slave_sync_response
);
  logic [7:0] wait_q;

  // answers answer_delay cycles after the request; 8'hFF never answers, like a dead slave
  always @(posedge clock) begin
    if (master_sync_request !== 1'b1) begin
      wait_q <= 8'h00;
      slave_sync_response <= 1'b0;
    end else if (answer_delay != 8'hFF && wait_q >= answer_delay) begin
      slave_sync_response <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the sync line register bank
`timescale 1ns/1ns
module tb;
  import sync_line_pkg::*;
  localparam int TO = 20;
  logic clk = 0, arst_n = 0, mrst = 0, init = 0, wr_en = 0, rd_en = 0, ovr = 0;
  logic msync = 0, stored = 0, ssync, rd_valid, rx_clr, strip;
  logic [2:0]  sel = 0, bits = 0;
  logic [1:0]  ben = 0;
  logic [15:0] wdata = 0, rd_data, dec;
  logic [7:0]  delay = 8'hFF;
  logic [3:0]  rx_bpc, tx_bpc;
  proto_t      proto;
  errctl_t     ec;
  int          failures = 0, comparisons = 0, cycles = 0, clears = 0, n;
  // parameter words beside their decode {0,proto,errctl,strip,rx,tx}
  logic [15:0] rows_d [9] = '{16'h0000, 16'h2149, 16'h4212, 16'h631B, 16'h9C24,
                              16'hA52D, 16'hC636, 16'hE73F, 16'h0078};
  logic [15:0] rows_e [9] = '{16'h0188, 16'h1311, 16'h2522, 16'h3733, 16'h3944,
                              16'h3B55, 16'h3D66, 16'h4E77, 16'h4188};

  assign dec = {1'b0, proto, ec, strip, rx_bpc, tx_bpc};

  sync_line_regs #(.TIMEOUT_CYCLES(TO)) u_dut (
    .CLOCK(clk), .ARST_N(arst_n), .MASTER_RESET(mrst), .BUS_INIT(init), .IND_SEL(sel),
    .BYTE_EN(ben), .WR_EN(wr_en), .WR_DATA(wdata), .RD_EN(rd_en), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .RX_OVERRUN_EVENT(ovr), .MASTER_SYNC_REQUEST(msync),
    .SLAVE_SYNC_RESPONSE(ssync), .LAST_CHAR_STORED(stored), .LAST_CHAR_BITS(bits),
    .RX_ENABLE_CLEAR(rx_clr), .PROTOCOL(proto), .ERROR_CONTROL(ec), .STRIP_SYNC(strip),
    .RX_BITS_PER_CHAR(rx_bpc), .TX_BITS_PER_CHAR(tx_bpc));

  dma_slave_model u_slave (.clock(clk), .master_sync_request(msync),
    .answer_delay(delay), .slave_sync_response(ssync));

  // clock, pulse counting and a hang limit well past the expected run
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      give_verdict();
    end
  end

  // pulses counted at the falling edge, where the registered output has settled
  always @(negedge clk) begin
    if (rx_clr === 1'b1) clears++;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus cycles start at a falling edge and are taken at the next rising edge
  task automatic wr(input logic [2:0] s, input logic [1:0] be, input logic [15:0] d);
    sel = s; ben = be; wdata = d; wr_en = 1;
    @(negedge clk) wr_en = 0;
  endtask

  task automatic rdc(input logic [2:0] s, input logic [1:0] be, input logic [15:0] exp);
    sel = s; ben = be; rd_en = 1;
    @(negedge clk) rd_en = 0;
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk("rd_data", exp, rd_data);
    @(negedge clk); // idle cycle, so a following read never re-raises rd_en in the same step
  endtask

  // one-cycle pulse on an event or reset input
  task automatic pulse(ref logic p);
    p = 1;
    @(negedge clk) p = 0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1;
    chk("decode", 16'h0188, dec);
    rdc(3'h1, 2'b11, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      wr(3'h0, 2'b11, rows_d[i]);
      repeat (2) @(negedge clk);
      chk("decode", rows_e[i], dec);
      rdc(3'h0, 2'b11, rows_d[i]);
    end
    $display("decode table done");
    // overrun flag set by its event, cleared by the read, by master reset and by init
    pulse(ovr);
    rdc(3'h1, 2'b01, 16'h0002);
    rdc(3'h1, 2'b01, 16'h0000);
    pulse(ovr);
    pulse(mrst);
    rdc(3'h1, 2'b01, 16'h0000);
    chk("decode", 16'h4188, dec);
    pulse(ovr);
    pulse(init);
    rdc(3'h1, 2'b01, 16'h0000);
    wr(3'h1, 2'b01, 16'hFFFF);
    rdc(3'h1, 2'b01, 16'h0000);
    bits = 3'h5;
    pulse(stored);
    rdc(3'h1, 2'b11, 16'h0500);
    // event and clearing read in one cycle: the set wins, the read sees the old byte
    sel = 3'h1;
    ben = 2'b01;
    rd_en = 1;
    ovr = 1;
    @(negedge clk);
    rd_en = 0;
    ovr = 0;
    chk("rd_data", 16'h0000, rd_data);
    @(negedge clk);
    chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
    rdc(3'h1, 2'b01, 16'h0002);
    rdc(3'h1, 2'b01, 16'h0000);
    // software load of the residual count, then a store pulse beating a write
    wr(3'h1, 2'b10, 16'h0300);
    rdc(3'h1, 2'b10, 16'h0300);
    bits = 3'h6;
    stored = 1;
    wr(3'h1, 2'b10, 16'h0200);
    stored = 0;
    rdc(3'h1, 2'b10, 16'h0600);
    $display("error flag test done");
    // dead slave: the watchdog must fire, not before its count, and stop reception
    msync = 1;
    n = 0;
    while (rx_clr !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("timeout_cycles", 16'(TO + 2), 16'(n));
    chk("not_early", 16'h0001, {15'h0000, n > TO});
    @(negedge clk);
    chk("rx_clr", 16'h0000, {15'h0000, rx_clr});
    // request still up: one report per request, no second pulse
    repeat (30) @(negedge clk);
    chk("clear_count", 16'h0001, 16'(clears));
    msync = 0;
    rdc(3'h1, 2'b01, 16'h0004);
    rdc(3'h1, 2'b01, 16'h0000);
    msync = 1;
    repeat (40) @(negedge clk);
    msync = 0;
    pulse(mrst);
    rdc(3'h1, 2'b01, 16'h0000);
    msync = 1;
    repeat (30) @(negedge clk);
    msync = 0;
    pulse(init);
    rdc(3'h1, 2'b01, 16'h0000);
    // prompt slave: no error; software then re-enables the receiver outside this block
    delay = 8'h02;
    clears = 0;
    msync = 1;
    repeat (40) @(negedge clk);
    msync = 0;
    chk("clear_count", 16'h0000, 16'(clears));
    rdc(3'h1, 2'b01, 16'h0000);
    $display("dma watchdog test done");
    // mid-run reset: the word, the flags and the residual count all go back
    wr(3'h0, 2'b11, 16'hE73F);
    pulse(ovr);
    arst_n = 0;
    repeat (2) @(negedge clk);
    chk("decode", 16'h0188, dec);
    chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
    arst_n = 1;
    chk("decode", 16'h0188, dec);
    rdc(3'h1, 2'b11, 16'h0000);
    rdc(3'h0, 2'b11, 16'h0000);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
